// *** verilog/tpc_timer.sv ***
// Timer with shared counter, modulo and capture/compare/PWM channels on AXI4-Lite
// Notes on behaviour
// - Output compare with level select 11 drives pin high on match.
// - Edge PWM: 10 clears on match, X1 sets on match.
// - Center PWM: high-true clears on up match, sets on down match; low-true opposite.
// - Reset clears every channel value.
// - Capture mode: reading one byte latches the other; the next value read of either byte returns it.
// - Channel control write resets that channel's coherency latches, even halted.
// - Capture mode ignores writes to channel value bytes.
// - Debug halt freezes latches; value reads return the live register.
// - Compare/PWM writes buffered; with no clock, load on second byte.
// - Compare mode with clock: load at next counter change after both bytes.
// - PWM with clock: load when counter steps modulo-1 to modulo (or to FFFF).
// - Debug halt writes go straight to the channel register.
// - Halt writes leave a partial buffered write intact; it completes later.
// - Center-select puts all channels in center PWM and counter up/down.
// - Clock select resets to 00; 00 stops counting, keeps all values.
// - External clock is synchronised; it must be under a quarter bus rate.
// - Shared clock pin not for capture; level select 00 leaves pin undriven.
// - Overflow enable raises interrupt while overflow flag is set.
// - Up mode wraps terminal count to zero and sets overflow flag.
// - Center mode sets overflow flag turning down from modulo.
// - Up/down counter turns at terminal and zero, each one tick long.
// - Any counter write clears it and resets its read latch.
// - Clock field: 00 none, 01 bus, 10 fixed, 11 external.
// - Prescaler divides by 1 to 128; new value acts next cycle.
// - Flag cleared by read while set then write 0; new event wins.
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_timer import tpc_pkg::*; #(
	parameter int CHANNELS = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fixed_clk_tick,
	input wire logic ext_clk_pin,
	input wire logic [CHANNELS-1:0] chan_pin_in,
	output logic [CHANNELS-1:0] chan_pin_out,
	output logic [CHANNELS-1:0] chan_pin_oe,
	output logic overflow_irq,
	output logic [CHANNELS-1:0] channel_irq
);
	// Bus slave: write address and data latched independently
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire wr_go = aw_held && w_held && !s_axi_bvalid;
	wire rd_go = s_axi_arvalid && !s_axi_rvalid;
	wire [7:0] ar_addr = s_axi_araddr[7:0];
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_arready = !s_axi_rvalid;
	wire wr_byte_ok = w_strb[0];

	// Global registers
	logic overflow_flag, overflow_irq_enable, center_align_select;
	logic [1:0] clk_sel;
	logic [2:0] prescale_field;
	logic debug_halt_mode;
	logic [15:0] counter, modulo, mod_buf;
	logic count_down;
	logic [7:0] cnt_rd_buf;
	logic cnt_rd_latched, tof_armed, mod_hi_done, mod_lo_done;

	wire wr_sc = wr_go && aw_addr == `TPC_OFF_SC && wr_byte_ok;
	wire wr_cnt = wr_go && (aw_addr == `TPC_OFF_CNTH || aw_addr == `TPC_OFF_CNTL) && wr_byte_ok;
	wire wr_modh = wr_go && aw_addr == `TPC_OFF_MODH && wr_byte_ok;
	wire wr_modl = wr_go && aw_addr == `TPC_OFF_MODL && wr_byte_ok;
	wire wr_dbg = wr_go && aw_addr == `TPC_OFF_DBG && wr_byte_ok;
	wire rd_sc = rd_go && ar_addr == `TPC_OFF_SC;
	wire rd_cnth = rd_go && ar_addr == `TPC_OFF_CNTH;
	wire rd_cntl = rd_go && ar_addr == `TPC_OFF_CNTL;

	// External clock synchroniser and edge detect
	logic ext_s1, ext_s2, ext_s3;
	wire ext_rise = ext_s2 && !ext_s3;

	// Clock selection and prescaler
	logic [6:0] presc;
	logic src_tick;
	assign src_tick = (clk_sel == `TPC_CLK_BUS) ? 1'b1 :
		(clk_sel == `TPC_CLK_FIXED) ? fixed_clk_tick :
		(clk_sel == `TPC_CLK_EXT) ? ext_rise : 1'b0;
	wire [6:0] presc_mask = 7'((8'h01 << prescale_field) - 8'h01);
	wire presc_wrap = (presc & presc_mask) == presc_mask;
	wire count_tick = src_tick && presc_wrap && !debug_halt_mode;

	// Counter terminal and turning points
	wire [15:0] terminal = (modulo == 16'h0000) ? `TPC_CNT_MAX : modulo;
	wire up_wrap = !center_align_select && counter == terminal;
	wire turn_down = center_align_select && !count_down && counter == terminal;
	wire turn_up = center_align_select && count_down && counter == 16'h0000;
	wire step_down = turn_down || (center_align_select && count_down && !turn_up);
	wire [15:0] next_counter = up_wrap ? 16'h0000 : step_down ? counter - 16'h0001 : counter + 16'h0001;
	wire tof_set = count_tick && tof_armed && (up_wrap || turn_down);
	wire pwm_load_pt = count_tick && !count_down && next_counter == terminal;

	always_ff @(posedge aclk) begin
		ext_s1 <= ext_clk_pin;
		ext_s2 <= ext_s1;
		ext_s3 <= ext_s2;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc <= 7'h00;
		end else if (src_tick && !debug_halt_mode) begin
			presc <= presc_wrap ? 7'h00 : presc + 7'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter <= 16'h0000;
			count_down <= 1'b0;
		end else if (wr_cnt) begin
			counter <= 16'h0000;
			count_down <= 1'b0;
		end else if (count_tick) begin
			counter <= next_counter;
			if (turn_down) begin
				count_down <= 1'b1;
			end else if (turn_up || !center_align_select) begin
				count_down <= 1'b0;
			end
		end
	end

	// Status/control, overflow flag with read-then-write-0 clear
	logic tof_seen;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_flag <= 1'b0;
			tof_seen <= 1'b0;
			overflow_irq_enable <= 1'b0;
			center_align_select <= 1'b0;
			clk_sel <= `TPC_CLK_NONE;
			prescale_field <= 3'b000;
			debug_halt_mode <= 1'b0;
		end else begin
			if (tof_set) begin
				overflow_flag <= 1'b1;
			end else if (wr_sc && !w_data[`TPC_SC_TOF] && tof_seen) begin
				overflow_flag <= 1'b0;
			end
			if (rd_sc && overflow_flag) begin
				tof_seen <= 1'b1;
			end else if (wr_sc || tof_set) begin
				tof_seen <= 1'b0;
			end
			if (wr_sc) begin
				overflow_irq_enable <= w_data[`TPC_SC_OVERFLOW_IRQ_ENABLE];
				center_align_select <= w_data[`TPC_SC_CENTER_ALIGN_SELECT];
				clk_sel <= w_data[4:3];
				prescale_field <= w_data[2:0];
			end
			if (wr_dbg) begin
				debug_halt_mode <= w_data[0];
			end
		end
	end

	// Counter read coherency and modulo write buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_rd_latched <= 1'b0;
			cnt_rd_buf <= 8'h00;
			modulo <= 16'h0000;
			mod_buf <= 16'h0000;
			mod_hi_done <= 1'b0;
			mod_lo_done <= 1'b0;
			tof_armed <= 1'b1;
		end else begin
			if (wr_sc || wr_cnt) begin
				cnt_rd_latched <= 1'b0;
			end else if (!debug_halt_mode && (rd_cnth || rd_cntl)) begin
				cnt_rd_latched <= !cnt_rd_latched;
				if (!cnt_rd_latched) begin
					cnt_rd_buf <= rd_cnth ? counter[7:0] : counter[15:8];
				end
			end
			if (wr_sc) begin
				mod_hi_done <= 1'b0;
				mod_lo_done <= 1'b0;
				tof_armed <= 1'b1;
			end else if (debug_halt_mode && (wr_modh || wr_modl)) begin
				if (wr_modh) modulo[15:8] <= w_data[7:0];
				if (wr_modl) modulo[7:0] <= w_data[7:0];
			end else if (wr_modh || wr_modl) begin
				if (wr_modh) mod_buf[15:8] <= w_data[7:0];
				if (wr_modl) mod_buf[7:0] <= w_data[7:0];
				mod_hi_done <= mod_hi_done || wr_modh;
				mod_lo_done <= mod_lo_done || wr_modl;
				tof_armed <= (mod_hi_done || wr_modh) && (mod_lo_done || wr_modl);
				if (clk_sel == `TPC_CLK_NONE && (mod_hi_done || wr_modh) && (mod_lo_done || wr_modl)) begin
					modulo <= {wr_modh ? w_data[7:0] : mod_buf[15:8], wr_modl ? w_data[7:0] : mod_buf[7:0]};
					mod_hi_done <= 1'b0;
					mod_lo_done <= 1'b0;
				end
			end else if (mod_hi_done && mod_lo_done && pwm_load_pt) begin
				modulo <= mod_buf;
				mod_hi_done <= 1'b0;
				mod_lo_done <= 1'b0;
			end
		end
	end

	assign overflow_irq = overflow_irq_enable && overflow_flag;

	// Per-channel logic
	logic [7:0] ch_rd_data [CHANNELS];
	logic [CHANNELS-1:0] ch_rd_hit;
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			localparam logic [7:0] BASE = 8'(`TPC_OFF_CH_BASE + g * `TPC_CH_STRIDE);
			logic chf, chf_seen, chie, msb, msa;
			logic [1:0] els;
			logic [15:0] value, wbuf;
			logic [7:0] rbuf;
			logic rd_latched, wh_done, wl_done, pin, pin_s1, pin_s2, pin_s3;
			tpc_mode_e mode;
			assign mode = center_align_select ? TPC_CENTER_PWM : msb ? TPC_EDGE_PWM :
				msa ? TPC_OUTPUT_COMPARE : TPC_INPUT_CAPTURE;
			wire capture = mode == TPC_INPUT_CAPTURE;
			wire w_sc = wr_go && aw_addr == BASE + 8'(`TPC_CH_SC) && wr_byte_ok;
			wire w_vh = wr_go && aw_addr == BASE + 8'(`TPC_CH_VH) && wr_byte_ok && !capture;
			wire w_vl = wr_go && aw_addr == BASE + 8'(`TPC_CH_VL) && wr_byte_ok && !capture;
			wire r_sc = rd_go && ar_addr == BASE + 8'(`TPC_CH_SC);
			wire r_vh = rd_go && ar_addr == BASE + 8'(`TPC_CH_VH);
			wire r_vl = rd_go && ar_addr == BASE + 8'(`TPC_CH_VL);
			wire both_done = (wh_done || w_vh) && (wl_done || w_vl);
			wire pin_rise = pin_s2 && !pin_s3;
			wire pin_fall = !pin_s2 && pin_s3;
			wire cap_ev = capture && ((els[0] && pin_rise) || (els[1] && pin_fall));
			wire match = count_tick && next_counter == value;
			wire pwm_full = (mode == TPC_EDGE_PWM && (value == 16'h0000 || value > modulo)) ||
				(mode == TPC_CENTER_PWM && (value == 16'h0000 || value[15] || value > modulo));
			wire cmp_ev = !capture && match && !pwm_full;
			wire ch_ev = cap_ev || cmp_ev;
			wire load_due = (mode == TPC_OUTPUT_COMPARE) ? count_tick : pwm_load_pt;
			always_ff @(posedge aclk) begin
				pin_s1 <= chan_pin_in[g];
				pin_s2 <= pin_s1;
				pin_s3 <= pin_s2;
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					chf <= 1'b0;
					chf_seen <= 1'b0;
					chie <= 1'b0;
					msb <= 1'b0;
					msa <= 1'b0;
					els <= 2'b00;
				end else begin
					if (ch_ev) begin
						chf <= 1'b1;
					end else if (w_sc && !w_data[`TPC_CSC_CHF] && chf_seen) begin
						chf <= 1'b0;
					end
					if (r_sc && chf) begin
						chf_seen <= 1'b1;
					end else if (w_sc || ch_ev) begin
						chf_seen <= 1'b0;
					end
					if (w_sc) begin
						chie <= w_data[`TPC_CSC_CHIE];
						msb <= w_data[5];
						msa <= w_data[4];
						els <= w_data[3:2];
					end
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					value <= 16'h0000;
					wbuf <= 16'h0000;
					rbuf <= 8'h00;
					rd_latched <= 1'b0;
					wh_done <= 1'b0;
					wl_done <= 1'b0;
				end else if (w_sc) begin
					rd_latched <= 1'b0;
					wh_done <= 1'b0;
					wl_done <= 1'b0;
				end else if (cap_ev) begin
					value <= counter;
				end else if (debug_halt_mode) begin
					if (w_vh) value[15:8] <= w_data[7:0];
					if (w_vl) value[7:0] <= w_data[7:0];
				end else if (w_vh || w_vl) begin
					if (w_vh) wbuf[15:8] <= w_data[7:0];
					if (w_vl) wbuf[7:0] <= w_data[7:0];
					wh_done <= wh_done || w_vh;
					wl_done <= wl_done || w_vl;
					if (clk_sel == `TPC_CLK_NONE && both_done) begin
						value <= {w_vh ? w_data[7:0] : wbuf[15:8], w_vl ? w_data[7:0] : wbuf[7:0]};
						wh_done <= 1'b0;
						wl_done <= 1'b0;
					end
				end else if (wh_done && wl_done && load_due) begin
					value <= wbuf;
					wh_done <= 1'b0;
					wl_done <= 1'b0;
				end else if (capture && (r_vh || r_vl)) begin
					rd_latched <= !rd_latched;
					if (!rd_latched) begin
						rbuf <= r_vh ? value[7:0] : value[15:8];
					end
				end
			end
			// Pin driver
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pin <= 1'b0;
				end else if (mode == TPC_OUTPUT_COMPARE && cmp_ev) begin
					case (els)
						2'b01: pin <= !pin;
						2'b10: pin <= 1'b0;
						2'b11: pin <= 1'b1;
						default: pin <= pin;
					endcase
				end else if (mode == TPC_EDGE_PWM) begin
					if (count_tick && up_wrap) begin
						pin <= !els[0];
					end else if (match || (value == 16'h0000 && count_tick)) begin
						pin <= els[0];
					end
				end else if (mode == TPC_CENTER_PWM && match) begin
					pin <= step_down ^ els[0];
				end
			end
			assign chan_pin_out[g] = pin;
			assign chan_pin_oe[g] = els != 2'b00 && !capture;
			assign channel_irq[g] = chie && chf;
			assign ch_rd_hit[g] = r_sc || r_vh || r_vl;
			assign ch_rd_data[g] = r_sc ? {chf, chie, msb, msa, els, 2'b00} :
				(capture && rd_latched && !debug_halt_mode) ? rbuf :
				r_vh ? value[15:8] : value[7:0];
		end
	endgenerate

	// Read mux
	logic [7:0] ch_sel_data;
	always_comb begin
		ch_sel_data = 8'h00;
		for (int i = 0; i < CHANNELS; i++) begin
			if (ch_rd_hit[i]) ch_sel_data = ch_rd_data[i];
		end
	end
	wire cnt_use_buf = cnt_rd_latched && !debug_halt_mode;
	wire [7:0] rd_byte = rd_sc ? {overflow_flag, overflow_irq_enable, center_align_select, clk_sel, prescale_field} :
		rd_cnth ? (cnt_use_buf ? cnt_rd_buf : counter[15:8]) :
		rd_cntl ? (cnt_use_buf ? cnt_rd_buf : counter[7:0]) :
		(ar_addr == `TPC_OFF_MODH) ? modulo[15:8] :
		(ar_addr == `TPC_OFF_MODL) ? modulo[7:0] :
		(ar_addr == `TPC_OFF_DBG) ? {7'h00, debug_halt_mode} : ch_sel_data;
	wire rd_mapped = rd_sc || rd_cnth || rd_cntl || ar_addr == `TPC_OFF_MODH ||
		ar_addr == `TPC_OFF_MODL || ar_addr == `TPC_OFF_DBG || |ch_rd_hit;
	wire wr_mapped = wr_sc || wr_cnt || wr_modh || wr_modl || wr_dbg ||
		(aw_addr >= `TPC_OFF_CH_BASE && aw_addr < 8'(`TPC_OFF_CH_BASE + CHANNELS * `TPC_CH_STRIDE)
		&& aw_addr[3:0] <= `TPC_CH_VL && aw_addr[1:0] == 2'b00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TPC_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `TPC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr[7:0];
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_mapped || !wr_byte_ok) ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
				s_axi_rresp <= rd_mapped ? `TPC_RESP_OKAY : `TPC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : tpc_timer

// *** verilog/tpc_defines.svh ***
// Register offsets, field positions and timing constants for the timer block
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
`define TPC_OFF_SC 8'h00
`define TPC_OFF_CNTH 8'h04
`define TPC_OFF_CNTL 8'h08
`define TPC_OFF_MODH 8'h0C
`define TPC_OFF_MODL 8'h10
`define TPC_OFF_DBG 8'h14
`define TPC_OFF_CH_BASE 8'h20
`define TPC_CH_STRIDE 8'h10
`define TPC_CH_SC 4'h0
`define TPC_CH_VH 4'h4
`define TPC_CH_VL 4'h8
`define TPC_SC_TOF 7
`define TPC_SC_OVERFLOW_IRQ_ENABLE 6
`define TPC_SC_CENTER_ALIGN_SELECT 5
`define TPC_CSC_CHF 7
`define TPC_CSC_CHIE 6
`define TPC_CLK_NONE 2'b00
`define TPC_CLK_BUS 2'b01
`define TPC_CLK_FIXED 2'b10
`define TPC_CLK_EXT 2'b11
`define TPC_RESP_OKAY 2'b00
`define TPC_RESP_SLVERR 2'b10
`define TPC_CNT_MAX 16'hFFFF
`endif

// *** verilog/tpc_pkg.sv ***
// Types shared by the timer block
package tpc_pkg;
	typedef enum logic [1:0] {
		TPC_INPUT_CAPTURE,
		TPC_OUTPUT_COMPARE,
		TPC_EDGE_PWM,
		TPC_CENTER_PWM
	} tpc_mode_e;
endpackage : tpc_pkg

// *** tb/tpc_timer_props.sv ***
// Bus and output assertions for the timer block
`timescale 1ns/1ps
module tpc_timer_props #(
	parameter int CHANNELS = 2
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic fixed_clk_tick,
	input wire logic ext_clk_pin,
	input wire logic [CHANNELS-1:0] chan_pin_in,
	input wire logic [CHANNELS-1:0] chan_pin_out,
	input wire logic [CHANNELS-1:0] chan_pin_oe,
	input wire logic overflow_irq,
	input wire logic [CHANNELS-1:0] channel_irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while answer pending");
	a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write answer missing");
	a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_ovf_irq_holds: assert property (overflow_irq |=> overflow_irq || $rose(s_axi_bvalid))
		else $error("overflow request fell without a write");
	a_chan_irq_holds: assert property (channel_irq != '0 |=>
		(channel_irq & $past(channel_irq)) == $past(channel_irq) || $rose(s_axi_bvalid))
		else $error("channel request fell without a write");
	a_reset_quiet: assert property ($rose(aresetn) |-> chan_pin_out == '0 && !overflow_irq && channel_irq == '0)
		else $error("outputs not cleared by reset");
endmodule : tpc_timer_props

bind tpc_timer tpc_timer_props #(.CHANNELS(CHANNELS)) i_props (.*);

// *** tb/tpc_pin_model.sv ***
// Far-side model of the channel pins and alternate clock sources
`timescale 1ns/1ps
module tpc_pin_model #(
	parameter int CHANNELS = 2
) (
	input wire logic aclk,
	input wire logic [CHANNELS-1:0] cap_lvl,
	output logic ext_clk_pin,
	output logic fixed_clk_tick,
	output logic [CHANNELS-1:0] chan_pin_in
);
	logic [2:0] div;
	initial begin
		div = 3'h0;
		ext_clk_pin = 1'b0;
		fixed_clk_tick = 1'b0;
		chan_pin_in = '0;
	end
	always @(posedge aclk) begin
		div <= div + 3'h1;
		ext_clk_pin <= div[2];
		fixed_clk_tick <= div[0];
		chan_pin_in <= cap_lvl;
	end
endmodule : tpc_pin_model

// *** tb/tpc_timer_tb.sv ***
// Self-checking bench for the timer block
`timescale 1ns/1ps
`include "tpc_defines.svh"
module tpc_timer_tb;
	localparam int CHANNELS = 2;
	localparam logic [7:0] CH0 = `TPC_OFF_CH_BASE;
	localparam logic [7:0] CH1 = `TPC_OFF_CH_BASE + `TPC_CH_STRIDE;
	logic aclk, aresetn;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, overflow_irq;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, bresp;
	logic fixed_clk_tick, ext_clk_pin;
	logic [CHANNELS-1:0] chan_pin_in, chan_pin_out, chan_pin_oe, channel_irq, cap_lvl;
	logic [7:0] v;
	logic [15:0] c, c2;
	int bad_count, checked;
	logic [7:0] src_sc [4] = '{8'h08, 8'h10, 8'h18, 8'h0B};
	int src_div [4] = '{1, 2, 8, 8};
	logic [7:0] pwm_top [3] = '{8'h0A, 8'h0A, 8'h2A};
	logic [7:0] pwm_ch [3] = '{8'h28, 8'h24, 8'h28};
	logic pwm_pol [3] = '{1'b1, 1'b0, 1'b1};

	tpc_timer #(.CHANNELS(CHANNELS)) i_dut (.*);
	tpc_pin_model #(.CHANNELS(CHANNELS)) i_pins (.*);

	initial aclk = 1'b0;
	always #25 aclk = ~aclk;

	task automatic results;
		if (bad_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (e !== g) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_awaddr <= {24'h00_0000, a};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		if (!s_axi_bvalid) bad_count++;
		bresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(posedge aclk);
		n = 0;
		s_axi_araddr <= {24'h00_0000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		if (!s_axi_rvalid) bad_count++;
		d = s_axi_rdata[7:0];
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rd_cnt(output logic [15:0] r);
		rd(`TPC_OFF_CNTH, r[15:8]);
		rd(`TPC_OFF_CNTL, r[7:0]);
	endtask : rd_cnt

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = '0;
		s_axi_wdata = '0;
		s_axi_araddr = '0;
		s_axi_wstrb = 4'h1;
		cap_lvl = '0;
		bad_count = 0;
		checked = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(CH0 + `TPC_CH_VH, v); chk("ch0 high reset", 16'h0000, v);
		rd(CH1 + `TPC_CH_VL, v); chk("ch1 low reset", 16'h0000, v);
		rd(`TPC_OFF_SC, v); chk("clock field reset", 16'h0000, v[4:3]);
		wr(8'h18, 8'h00); chk("unmapped resp", `TPC_RESP_SLVERR, bresp);
		// Each clock source and a prescaled bus clock, free running
		for (int k = 0; k < 4; k++) begin
			wr(`TPC_OFF_CNTL, 8'h5A);
			wr(`TPC_OFF_SC, src_sc[k]);
			repeat (96) @(posedge aclk);
			wr(`TPC_OFF_SC, 8'h00);
			rd_cnt(c);
			chk("count rate", 16'h0001, c >= 96 / src_div[k] - 2 && c <= 96 / src_div[k] + 8);
			rd_cnt(c2); chk("stopped count", c, c2);
		end
		wr(`TPC_OFF_CNTH, 8'hFF); rd_cnt(c); chk("counter cleared", 16'h0000, c);
		// Output compare, set on match, loaded at once with no clock
		wr(CH0, 8'h1C);
		wr(CH0 + `TPC_CH_VH, 8'h01);
		rd(CH0 + `TPC_CH_VH, v); chk("half written value", 16'h0000, v);
		wr(CH0 + `TPC_CH_VL, 8'h40);
		rd(CH0 + `TPC_CH_VH, v); chk("value high loaded", 16'h0001, v);
		chk("pin before match", 16'h0002, {chan_pin_oe[0], chan_pin_out[0]});
		wr(`TPC_OFF_SC, 8'h08);
		repeat (400) @(posedge aclk);
		wr(`TPC_OFF_SC, 8'h00);
		chk("pin after match", 16'h0001, chan_pin_out[0]);
		rd(CH0, v); chk("compare flag", 16'h0001, v[7]);
		wr(CH0, 8'h1C); rd(CH0, v); chk("flag cleared", 16'h0000, v[7]);
		wr(CH0 + `TPC_CH_VL, 8'h34);
		wr(`TPC_OFF_DBG, 8'h01);
		wr(CH0 + `TPC_CH_VH, 8'hAB); rd(CH0 + `TPC_CH_VH, v); chk("halt write direct", 16'h00AB, v);
		wr(`TPC_OFF_DBG, 8'h00);
		wr(CH0 + `TPC_CH_VH, 8'h12); rd(CH0 + `TPC_CH_VL, v); chk("partial write low", 16'h0034, v);
		rd(CH0 + `TPC_CH_VH, v); chk("partial write high", 16'h0012, v);
		// Capture on ch1 with the counter frozen
		wr(CH1, 8'h44);
		wr(CH1 + `TPC_CH_VH, 8'h55); rd(CH1 + `TPC_CH_VH, v); chk("capture ignores write", 16'h0000, v);
		wr(CH1, 8'h44);
		rd_cnt(c);
		cap_lvl <= 2'b10;
		repeat (8) @(posedge aclk);
		rd(CH1 + `TPC_CH_VL, c2[7:0]);
		rd(CH1 + `TPC_CH_VH, c2[15:8]);
		chk("captured value", c, c2);
		chk("channel request", 16'h0002, channel_irq);
		rd(CH1 + `TPC_CH_VL, v); wr(`TPC_OFF_DBG, 8'h01);
		rd(CH1 + `TPC_CH_VL, v); chk("halt reads live", c[7:0], v);
		wr(`TPC_OFF_DBG, 8'h00);
		rd(CH1 + `TPC_CH_VL, v); chk("latch kept over halt", c[15:8], v);
		// Overflow at the modulo value
		wr(`TPC_OFF_MODH, 8'h00);
		wr(`TPC_OFF_MODL, 8'h30);
		wr(`TPC_OFF_CNTL, 8'h00);
		wr(`TPC_OFF_SC, 8'h48);
		repeat (20) @(posedge aclk);
		chk("no early overflow", 16'h0000, overflow_irq);
		repeat (60) @(posedge aclk);
		chk("overflow request", 16'h0001, overflow_irq);
		wr(`TPC_OFF_SC, 8'h40);
		rd_cnt(c); chk("within modulo", 16'h0001, c <= 16'h0030);
		rd(`TPC_OFF_SC, v); wr(`TPC_OFF_SC, 8'h40); chk("overflow cleared", 16'h0000, overflow_irq);
		// Edge PWM both polarities, then center PWM
		wr(CH0 + `TPC_CH_VH, 8'h00);
		wr(CH0 + `TPC_CH_VL, 8'h10);
		for (int m = 0; m < 3; m++) begin
			wr(CH0, pwm_ch[m]);
			for (int j = 0; j < 4; j++) begin
				wr(`TPC_OFF_SC, pwm_top[m]);
				repeat (400 + 37 * j) @(posedge aclk);
				wr(`TPC_OFF_SC, pwm_top[m] & 8'hE7);
				rd_cnt(c);
				if (c != 16'h0010) chk("pwm pin", (c < 16'h0010) == pwm_pol[m], chan_pin_out[0]);
			end
		end
		// Buffered loads with the clock running
		wr(CH0, 8'h1C);
		wr(`TPC_OFF_SC, 8'h08);
		wr(CH0 + `TPC_CH_VH, 8'h00);
		wr(CH0 + `TPC_CH_VL, 8'h20); rd(CH0 + `TPC_CH_VL, v); chk("compare load on tick", 16'h0020, v);
		wr(CH0, 8'h28);
		wr(`TPC_OFF_CNTL, 8'h00);
		wr(CH0 + `TPC_CH_VH, 8'h00);
		wr(CH0 + `TPC_CH_VL, 8'h08); rd(CH0 + `TPC_CH_VL, v); chk("pwm load waits", 16'h0020, v);
		repeat (60) @(posedge aclk);
		rd(CH0 + `TPC_CH_VL, v); chk("pwm load at modulo", 16'h0008, v);
		results();
	end

	initial begin
		repeat (30000) @(posedge aclk);
		bad_count++;
		results();
	end
endmodule : tpc_timer_tb
